// >>> afectl_top.sv
// Function
// [R1] each amp input picks any channel
// [R2] common input selectable like any channel
// [R3] offset, temperature, supply, burnout monitor routes
// [R4] channel change: mid-supply two clocks first
// [R5] three-bit gain, one to 128
// [R6] enable 00 bypass off, 01 on
// [R7] host never writes enable 10 or 11
// [R8] gains 64/128: analog 32 plus digital
// [R9] four rail flags in status register
// [R10] rail detection only when enable bit set
// [R11] host bypasses only at gain one
// [R12] host bypasses for low-supply single-ended
// [R13] reference select field, reset external zero
// [R14] reference monitor flags during conversion
// [R15] select value 10 means internal reference
// [R16] rail flags low while detection disabled
`timescale 1ns/1ps
`include "afectl_params.svh"
module afectl_top
    import afectl_pkg::*;
(
    input  wire logic       mclk,          // system clock
    input  wire logic       rstn,          // sync reset, active low
    input  wire logic       reg_wr,        // register write strobe
    input  wire logic       reg_rd,        // register read strobe
    input  wire logic [7:0] reg_addr,      // register address
    input  wire logic [7:0] reg_wdata,     // write data
    output logic      [7:0] reg_rdata,     // read data, two cycles after strobe
    output logic            reg_rvalid,    // read data valid pulse
    input  wire logic [2:0] monitor_sel,   // system monitor select
    input  wire logic [3:0] rail_cmp,      // rail comparators: phi, plo, nhi, nlo
    input  wire logic [1:0] ref_low_cmp,   // reference low comparators, level 1..0
    input  wire logic       conv_active,   // conversion in progress
    input  wire logic       conv_start,    // conversion start pulse
    output logic      [3:0] pos_route,     // positive input channel, 12 = common
    output logic      [3:0] neg_route,     // negative input channel, 12 = common
    output logic            mid_short,     // both inputs tied to mid-supply
    output logic            mon_temp,      // temperature sensor routed
    output logic            mon_avdd4,     // analog supply over four routed
    output logic            mon_dvdd4,     // digital supply over four routed
    output logic            burnout_en,    // burnout current sources on
    output logic            amp_power,     // amplifier powered
    output logic            amp_bypass,    // amplifier bypassed
    output logic      [2:0] amp_gain,      // analog gain code, up to x32 while amp is powered
    output logic      [1:0] dig_shift,     // digital scale shift
    output logic      [1:0] ref_route,     // reference source driven to modulator
    output logic            rail_det_on    // rail detection circuit enabled
);

    logic [7:0] inmux_r, inmux_nxt;    // input channel select
    logic [7:0] gain_r, gain_nxt;      // amplifier gain setting
    logic [7:0] refctl_r, refctl_nxt;  // reference control
    logic [7:0] exc1_r, exc1_nxt;      // excitation current one
    logic [3:0] rail_r, rail_nxt;      // rail flags
    logic [1:0] refl_r, refl_nxt;      // reference low flags
    logic [7:0] rdata_r, rdata_nxt;    // read data
    logic       rvalid_r, rvalid_nxt;  // read valid
    logic [7:0] status;                // assembled status byte

    afectl_if mux ();

    // channel codes pass straight to the sequencer; code 12 is the common input
    assign mux.pos_req = inmux_r[`AFECTL_POS_MSB:`AFECTL_POS_LSB];  // [R1] [R2]
    assign mux.neg_req = inmux_r[`AFECTL_NEG_MSB:`AFECTL_NEG_LSB];  // [R1] [R2]

    afectl_bbm afectl_bbm_inst (
        .mclk (mclk),
        .rstn (rstn),
        .mux  (mux)
    );

    // status byte, reserved bits zero
    always_comb begin
        status                   = 8'h00;
        status[`AFECTL_ST_PHI]   = rail_r[3];
        status[`AFECTL_ST_PLO]   = rail_r[2];
        status[`AFECTL_ST_NHI]   = rail_r[1];
        status[`AFECTL_ST_NLO]   = rail_r[0];
        status[`AFECTL_ST_REF1]  = refl_r[1];
        status[`AFECTL_ST_REF0]  = refl_r[0];
    end

    // register writes and reads
    always_comb begin
        inmux_nxt  = inmux_r;
        gain_nxt   = gain_r;
        refctl_nxt = refctl_r;
        exc1_nxt   = exc1_r;
        rdata_nxt  = rdata_r;
        rvalid_nxt = 1'b0;
        if (reg_wr) begin
            // enable codes 10/11 are stored as written; the host must not use them
            if (reg_addr == `AFECTL_ADDR_INMUX) begin
                inmux_nxt = reg_wdata;
            end else if (reg_addr == `AFECTL_ADDR_GAIN) begin
                gain_nxt = reg_wdata;
            end else if (reg_addr == `AFECTL_ADDR_REFCTL) begin
                refctl_nxt = reg_wdata;
            end else if (reg_addr == `AFECTL_ADDR_EXC1) begin
                exc1_nxt = reg_wdata;
            end
        end
        if (reg_rd) begin
            rvalid_nxt = 1'b1;
            if (reg_addr == `AFECTL_ADDR_STATUS) begin
                rdata_nxt = status;  // [R9] [R14]
            end else if (reg_addr == `AFECTL_ADDR_INMUX) begin
                rdata_nxt = inmux_r;
            end else if (reg_addr == `AFECTL_ADDR_GAIN) begin
                rdata_nxt = gain_r;
            end else if (reg_addr == `AFECTL_ADDR_REFCTL) begin
                rdata_nxt = refctl_r;
            end else if (reg_addr == `AFECTL_ADDR_EXC1) begin
                rdata_nxt = exc1_r;
            end else begin
                rdata_nxt = 8'h00;  // unmapped reads zero
            end
        end
    end

    // monitor flags
    always_comb begin
        // rail flags follow comparators only while detection is on
        if (exc1_r[`AFECTL_RAIL_EN_BIT]) begin  // [R10]
            rail_nxt = rail_cmp;  // [R9]
        end else begin
            rail_nxt = 4'h0;  // [R16]
        end
        // reference flags are sticky within a conversion; a low seen in the
        // same cycle as the start still sets the flag
        refl_nxt = refl_r;
        if (conv_start) begin
            refl_nxt = 2'h0;
        end
        if (conv_active || conv_start) begin
            refl_nxt = refl_nxt | ref_low_cmp;  // [R14]
        end
    end

    // register stage for configuration, flags and read port
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            inmux_r  <= `AFECTL_RST_INMUX;
            gain_r   <= `AFECTL_RST_GAIN;
            refctl_r <= `AFECTL_RST_REFCTL;  // [R13]
            exc1_r   <= `AFECTL_RST_EXC1;
            rail_r   <= 4'h0;
            refl_r   <= 2'h0;
            rdata_r  <= 8'h00;
            rvalid_r <= 1'b0;
        end else begin
            inmux_r  <= inmux_nxt;
            gain_r   <= gain_nxt;
            refctl_r <= refctl_nxt;
            exc1_r   <= exc1_nxt;
            rail_r   <= rail_nxt;
            refl_r   <= refl_nxt;
            rdata_r  <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
        end
    end

    // analog control outputs, all registered
    logic [2:0] gsel;      // programmed gain code
    logic [1:0] ensel;     // programmed enable code
    logic [1:0] rsel;      // programmed reference select
    logic [2:0] mon;       // monitor select
    assign gsel  = gain_r[`AFECTL_GAIN_MSB:`AFECTL_GAIN_LSB];
    assign ensel = gain_r[`AFECTL_EN_MSB:`AFECTL_EN_LSB];
    assign rsel  = refctl_r[`AFECTL_REF_SOURCE_SEL_MSB:`AFECTL_REF_SOURCE_SEL_LSB];
    assign mon   = monitor_sel;

    always_ff @(posedge mclk) begin
        if (!rstn) begin
            pos_route   <= 4'h0;
            neg_route   <= 4'h1;
            mid_short   <= 1'b0;
            mon_temp    <= 1'b0;
            mon_avdd4   <= 1'b0;
            mon_dvdd4   <= 1'b0;
            burnout_en  <= 1'b0;
            amp_power   <= 1'b0;
            amp_bypass  <= 1'b1;
            amp_gain    <= 3'h0;
            dig_shift   <= 2'h0;
            ref_route   <= `AFECTL_REF_EXT0;  // [R13]
            rail_det_on <= 1'b0;
            reg_rdata   <= 8'h00;
            reg_rvalid  <= 1'b0;
        end else begin
            pos_route   <= mux.pos_route;
            neg_route   <= mux.neg_route;
            mid_short   <= mux.mid_short || (mon == AFECTL_MON_OFFSET);  // [R3] [R4]
            mon_temp    <= (mon == AFECTL_MON_TEMP);  // [R3]
            mon_avdd4   <= (mon == AFECTL_MON_AVDD4);  // [R3]
            mon_dvdd4   <= (mon == AFECTL_MON_DVDD4);  // [R3]
            burnout_en  <= (mon == AFECTL_MON_BURNOUT);  // [R3]
            // reserved enable codes fall back to the powered-on decode
            amp_power   <= (ensel != `AFECTL_EN_OFF);  // [R6]
            amp_bypass  <= (ensel == `AFECTL_EN_OFF);  // [R6] [R12]
            if ((ensel != `AFECTL_EN_OFF) && (gsel > `AFECTL_GAIN_X32)) begin
                amp_gain  <= `AFECTL_GAIN_X32;  // [R8]
                dig_shift <= 2'(gsel - `AFECTL_GAIN_X32);  // [R8]
            end else begin
                amp_gain  <= gsel;  // [R5] [R11]
                dig_shift <= 2'h0;
            end
            // select 11 is unused and falls back to external pair zero
            if (rsel == `AFECTL_REF_INT) begin
                ref_route <= `AFECTL_REF_INT;  // [R15]
            end else if (rsel == `AFECTL_REF_EXT1) begin
                ref_route <= `AFECTL_REF_EXT1;  // [R13]
            end else begin
                ref_route <= `AFECTL_REF_EXT0;  // [R13]
            end
            rail_det_on <= exc1_r[`AFECTL_RAIL_EN_BIT];  // [R10]
            reg_rdata   <= rdata_r;
            reg_rvalid  <= rvalid_r;
        end
    end

endmodule

// >>> afectl_params.svh
`ifndef AFECTL_PARAMS_SVH
`define AFECTL_PARAMS_SVH

// register addresses
`define AFECTL_ADDR_STATUS   8'h01
`define AFECTL_ADDR_INMUX    8'h02
`define AFECTL_ADDR_GAIN     8'h03
`define AFECTL_ADDR_REFCTL   8'h05
`define AFECTL_ADDR_EXC1     8'h06

// reset values
`define AFECTL_RST_INMUX     8'h01
`define AFECTL_RST_GAIN      8'h00
`define AFECTL_RST_REFCTL    8'h00
`define AFECTL_RST_EXC1      8'h00

// input mux fields
`define AFECTL_POS_MSB       7
`define AFECTL_POS_LSB       4
`define AFECTL_NEG_MSB       3
`define AFECTL_NEG_LSB       0

// gain register fields
`define AFECTL_EN_MSB        4
`define AFECTL_EN_LSB        3
`define AFECTL_GAIN_MSB      2
`define AFECTL_GAIN_LSB      0
`define AFECTL_GAIN_X32      3'h5
`define AFECTL_EN_OFF        2'h0
`define AFECTL_EN_ON         2'h1

// reference control fields
`define AFECTL_REF_SOURCE_SEL_MSB    3
`define AFECTL_REF_SOURCE_SEL_LSB    2
`define AFECTL_REF_EXT0      2'h0
`define AFECTL_REF_EXT1      2'h1
`define AFECTL_REF_INT       2'h2

// excitation current 1 fields
`define AFECTL_RAIL_EN_BIT   7

// status bit positions
`define AFECTL_ST_PHI        5
`define AFECTL_ST_PLO        4
`define AFECTL_ST_NHI        3
`define AFECTL_ST_NLO        2
`define AFECTL_ST_REF1       1
`define AFECTL_ST_REF0       0

// break-before-make hold, in system clock periods
`define AFECTL_BBM_TCLK      2
`define AFECTL_BBM_CYCLES    (`AFECTL_BBM_TCLK)

`endif

// >>> afectl_pkg.sv
package afectl_pkg;

    // break-before-make sequencer states, gray along idle-break-make
    typedef enum logic [1:0] {
        AFECTL_IDLE  = 2'b00,
        AFECTL_BREAK = 2'b01,
        AFECTL_MAKE  = 2'b11
    } afectl_state_t;

    // system monitor selections routed through the input mux
    typedef enum logic [2:0] {
        AFECTL_MON_NONE    = 3'h0,
        AFECTL_MON_OFFSET  = 3'h1,
        AFECTL_MON_TEMP    = 3'h2,
        AFECTL_MON_AVDD4   = 3'h3,
        AFECTL_MON_DVDD4   = 3'h4,
        AFECTL_MON_BURNOUT = 3'h5
    } afectl_mon_t;

endpackage

// >>> afectl_if.sv
`timescale 1ns/1ps
interface afectl_if;
    logic [3:0] pos_req;    // requested positive channel
    logic [3:0] neg_req;    // requested negative channel
    logic [3:0] pos_route;  // connected positive channel
    logic [3:0] neg_route;  // connected negative channel
    logic       mid_short;  // inputs held at mid-supply

    modport ctrl (output pos_req, output neg_req, input pos_route, input neg_route, input mid_short);
    modport seq  (input pos_req, input neg_req, output pos_route, output neg_route, output mid_short);
endinterface

// >>> afectl_bbm.sv
`timescale 1ns/1ps
`include "afectl_params.svh"
module afectl_bbm
    import afectl_pkg::*;
(
    input  wire logic mclk,  // system clock
    input  wire logic rstn,  // sync reset, active low
    afectl_if.seq     mux    // channel request and route
);

    afectl_state_t state_r, state_nxt;  // sequencer state
    logic [1:0]    cnt_r, cnt_nxt;      // break hold counter
    logic [3:0]    pos_r, pos_nxt;      // connected positive channel
    logic [3:0]    neg_r, neg_nxt;      // connected negative channel
    logic          mid_r, mid_nxt;      // mid-supply short

    // next state: any change of request breaks, holds, then makes
    always_comb begin
        state_nxt = state_r;
        cnt_nxt   = cnt_r;
        pos_nxt   = pos_r;
        neg_nxt   = neg_r;
        mid_nxt   = mid_r;
        case (state_r)
            AFECTL_IDLE: begin
                if ((mux.pos_req != pos_r) || (mux.neg_req != neg_r)) begin  // [R4]
                    state_nxt = AFECTL_BREAK;
                    mid_nxt   = 1'b1;
                    cnt_nxt   = 2'(`AFECTL_BBM_CYCLES - 1);
                end
            end
            AFECTL_BREAK: begin
                // a request changing mid-break is picked up at make time
                if (cnt_r == 2'h0) begin  // [R4]
                    state_nxt = AFECTL_MAKE;
                    pos_nxt   = mux.pos_req;
                    neg_nxt   = mux.neg_req;
                    mid_nxt   = 1'b0;
                end else begin
                    cnt_nxt = cnt_r - 2'h1;
                end
            end
            AFECTL_MAKE: begin
                state_nxt = AFECTL_IDLE;
            end
            default: begin
                state_nxt = AFECTL_IDLE;
            end
        endcase
    end

    // register stage
    always_ff @(posedge mclk) begin
        if (!rstn) begin
            state_r <= AFECTL_IDLE;
            cnt_r   <= 2'h0;
            pos_r   <= 4'h0;
            neg_r   <= 4'h1;
            mid_r   <= 1'b0;
        end else begin
            state_r <= state_nxt;
            cnt_r   <= cnt_nxt;
            pos_r   <= pos_nxt;
            neg_r   <= neg_nxt;
            mid_r   <= mid_nxt;
        end
    end

    assign mux.pos_route = pos_r;
    assign mux.neg_route = neg_r;
    assign mux.mid_short = mid_r;

endmodule

// >>> afectl_host.sv
`timescale 1ns/1ps
// host-side model: drives the register port, one byte per strobe
module afectl_host (
    input  wire logic       mclk,       // system clock
    output logic            reg_wr,     // write strobe
    output logic            reg_rd,     // read strobe
    output logic      [7:0] reg_addr,   // address
    output logic      [7:0] reg_wdata,  // write data
    input  wire logic [7:0] reg_rdata,  // read data
    input  wire logic       reg_rvalid  // read answer
);
    logic hung;  // last read got no answer in time

    // idle bus at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        hung = 1'b0;
    end

    // one write, strobe spans exactly one rising edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        if (a == 8'h03 && d[4]) d[4] = 1'b0;  // reserved enable codes never sent
        if (a == 8'h03 && d[4:3] == 2'h0) d[2:0] = 3'h0;  // bypass only at unity gain
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_addr = ~a;  // released lines show a changed pattern
        reg_wdata = ~d;
    endtask

    // one read, answer awaited for a bounded number of edges
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        int n;
        d = 'x;
        @(negedge mclk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd = 1'b0;
        reg_addr = ~a;
        hung = 1'b1;
        for (n = 0; n < 4 && hung; n++) begin
            @(posedge mclk);
            #1;
            if (reg_rvalid === 1'b1) begin
                hung = 1'b0;
                d = reg_rdata;
            end
        end
    endtask
endmodule

// >>> afectl_top_properties.sv
`timescale 1ns/1ps
module afectl_chk
    import afectl_pkg::*;
(
    input wire logic       mclk,         // clock
    input wire logic       rstn,         // reset, low
    input wire logic       reg_wr,       // write strobe
    input wire logic [7:0] reg_addr,     // address
    input wire logic [7:0] reg_wdata,    // write data
    input wire logic [7:0] reg_rdata,    // read data
    input wire logic       reg_rvalid,   // read answer
    input wire logic [2:0] monitor_sel,  // monitor select
    input wire logic [3:0] pos_route,    // positive route
    input wire logic [3:0] neg_route,    // negative route
    input wire logic       mid_short,    // mid-supply tie
    input wire logic       mon_temp,     // temperature route
    input wire logic       mon_avdd4,    // analog supply route
    input wire logic       mon_dvdd4,    // digital supply route
    input wire logic       burnout_en,   // burnout sources
    input wire logic       amp_power,    // amp powered
    input wire logic       amp_bypass,   // amp bypassed
    input wire logic [2:0] amp_gain,     // analog gain code
    input wire logic [1:0] dig_shift,    // digital shift
    input wire logic [1:0] ref_route,    // reference source
    input wire logic       rail_det_on   // rail detect on
);
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!rstn);

    // power, shift and analog code expected after a gain write
    function automatic logic [5:0] gexp(logic [7:0] w);
        if (w[4:3] != 2'h0 && w[2:0] > 3'h5)
            return {1'b1, w[1:0] - 2'h1, 3'h5};
        return {w[4:3] != 2'h0, 2'h0, w[2:0]};
    endfunction

    // unused select code falls back to external pair zero
    function automatic logic [1:0] rsel(logic [7:0] w);
        return (w[3:2] == 2'h3) ? 2'h0 : w[3:2];
    endfunction

    sequence s_mux_wr;
        reg_wr && reg_addr == 8'h02;
    endsequence
    sequence s_hold2;
        mid_short [*2];
    endsequence
    sequence s_broke;
        $past(mid_short, 1) && $past(mid_short, 2);
    endsequence

    chk_break_start: assert property ((s_mux_wr and (reg_wdata != {pos_route, neg_route})) |-> ##3 s_hold2)
        else $error("no mid-supply hold after channel change");
    chk_route_break: assert property ($changed(pos_route) || $changed(neg_route) |-> s_broke)
        else $error("route changed without break");
    chk_route_update: assert property (s_mux_wr |-> ##6 {pos_route, neg_route} == $past(reg_wdata, 6))
        else $error("routes differ from written channels");
    chk_monitor_supply: assert property (monitor_sel == 3'h3 && $past(monitor_sel) == 3'h3 |->
        ##1 mon_avdd4 && !mon_temp && !mon_dvdd4 && !burnout_en)
        else $error("supply monitor route wrong");
    chk_monitor_offset: assert property (monitor_sel == 3'h1 && $past(monitor_sel) == 3'h1 |->
        ##1 mid_short && !mon_temp)
        else $error("offset short not applied");
    chk_gain_scale: assert property (reg_wr && reg_addr == 8'h03 |->
        ##3 {amp_power, dig_shift, amp_gain} == gexp($past(reg_wdata, 3)))
        else $error("gain decode wrong");
    chk_bypass_pair: assert property (reg_wr && reg_addr == 8'h03 |->
        ##3 amp_bypass == ($past(reg_wdata[4:3], 3) == 2'h0) && amp_bypass != amp_power)
        else $error("bypass and power disagree");
    chk_ref_select: assert property (reg_wr && reg_addr == 8'h05 |-> ##3 ref_route == rsel($past(reg_wdata, 3)))
        else $error("reference route wrong");
    chk_rail_enable: assert property (reg_wr && reg_addr == 8'h06 |-> ##3 rail_det_on == $past(reg_wdata[7], 3))
        else $error("rail detect enable not followed");
    chk_rail_gated: assert property (reg_rvalid && $past(reg_addr, 2) == 8'h01 && !rail_det_on
        && !$past(rail_det_on) && !$past(rail_det_on, 2) && !$past(rail_det_on, 3) |-> reg_rdata[7:2] == 6'h00)
        else $error("rail flag set while detection off");
endmodule

bind afectl_top afectl_chk afectl_chk_inst (.mclk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .monitor_sel, .pos_route, .neg_route, .mid_short, .mon_temp, .mon_avdd4, .mon_dvdd4,
    .burnout_en, .amp_power, .amp_bypass, .amp_gain, .dig_shift, .ref_route, .rail_det_on);

// >>> tb_afectl_top.sv
`timescale 1ns/1ps
module tb_afectl_top
    import afectl_pkg::*;
;
    logic       mclk, rstn, reg_wr, reg_rd, reg_rvalid, mid_short, conv_active, conv_start;  // control
    logic       mon_temp, mon_avdd4, mon_dvdd4, burnout_en, amp_power, amp_bypass, rail_det_on;  // outputs
    logic [7:0] reg_addr, reg_wdata, reg_rdata, rv;  // bus and last read
    logic [3:0] pos_route, neg_route, rail_cmp;      // routes, comparators
    logic [2:0] monitor_sel, amp_gain;               // monitor, gain
    logic [1:0] dig_shift, ref_route, ref_low_cmp;   // scaling, reference
    logic [7:0] mux_tab [4] = '{8'hc5, 8'h3c, 8'hb0, 8'hb3};  // last entry moves one side only
    int         failures, n_compared, i, n, hi;      // tallies and loop indices

    afectl_top afectl_top_inst (.mclk, .rstn, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
        .reg_rvalid, .monitor_sel, .rail_cmp, .ref_low_cmp, .conv_active, .conv_start, .pos_route,
        .neg_route, .mid_short, .mon_temp, .mon_avdd4, .mon_dvdd4, .burnout_en, .amp_power,
        .amp_bypass, .amp_gain, .dig_shift, .ref_route, .rail_det_on);
    afectl_host afectl_host_inst (.mclk, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);

    // 125 MHz system clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    // verdict and end of run
    task automatic conclude();
        if (failures == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // read and compare; a lost answer ends the run
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp, input string what);
        afectl_host_inst.rd(a, rv);
        if (afectl_host_inst.hung) begin
            failures++;
            conclude();
        end
        check(what, rv, exp);
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask

    initial begin
        rstn = 1'b0;
        monitor_sel = 3'h0;
        rail_cmp = 4'h0;
        ref_low_cmp = 2'h0;
        conv_active = 1'b0;
        conv_start = 1'b0;
        failures = 0;
        n_compared = 0;
        tick(10);
        rstn = 1'b1;
        // reset state, read-only status, unmapped address
        rdc(8'h02, 8'h01, "inmux_rst");
        rdc(8'h03, 8'h00, "gain_rst");
        rdc(8'h05, 8'h00, "refctl_rst");
        rdc(8'h06, 8'h00, "exc1_rst");
        check("bypass_rst", {amp_power, amp_bypass, ref_route}, 4'h4);
        afectl_host_inst.wr(8'h01, 8'hff);
        rdc(8'h01, 8'h00, "status_ro");
        rdc(8'h04, 8'h00, "unmapped");
        // channel changes: count mid-supply cycles until the new pair shows
        for (i = 0; i < 4; i++) begin
            afectl_host_inst.wr(8'h02, mux_tab[i]);
            hi = 0;
            for (n = 0; n < 10 && {pos_route, neg_route} !== mux_tab[i]; n++) begin
                @(negedge mclk);
                hi += (mid_short === 1'b1);
            end
            if (n == 10) begin
                failures++;
                conclude();
            end
            check("break_cycles", hi[7:0], 8'h02);
            check("break_end", mid_short, 1'b0);
            rdc(8'h02, mux_tab[i], "inmux_rb");
        end
        // every monitor code, unused codes route nothing
        for (i = 0; i < 8; i++) begin
            tick(1);
            monitor_sel = i[2:0];
            tick(2);
            check("monitors", {mon_temp, mon_avdd4, mon_dvdd4, burnout_en, mid_short}, {i==2, i==3, i==4, i==5, i==1});
        end
        monitor_sel = 3'h0;
        // all gains with the amplifier on, then bypass at unity
        for (i = 0; i < 8; i++) begin
            afectl_host_inst.wr(8'h03, {5'h01, i[2:0]});
            tick(2);
            check("gain", {amp_power, amp_bypass, dig_shift, amp_gain}, {2'b10, (i > 5 ? i[1:0] - 2'h1 : 2'h0), (i > 5 ? 3'h5 : i[2:0])});
            rdc(8'h03, {5'h01, i[2:0]}, "gain_rb");
        end
        afectl_host_inst.wr(8'h03, 8'h00);
        tick(2);
        check("bypass", {amp_power, amp_bypass, dig_shift, amp_gain}, 7'h20);
        // select 11 falls back to pair zero; the sweep ends on the internal source
        for (i = 0; i < 4; i++) begin
            afectl_host_inst.wr(8'h05, {4'h0, 2'(i ^ 1), 2'h0});
            tick(2);
            check("ref_route", ref_route, (i == 2) ? 2'h0 : 2'(i ^ 1));
        end
        // rail flags: gated off, then one comparator at a time
        tick(1);
        rail_cmp = 4'hf;
        tick(3);
        rdc(8'h01, 8'h00, "rail_off");
        afectl_host_inst.wr(8'h06, 8'h80);
        tick(2);
        check("rail_on", rail_det_on, 1'b1);
        for (i = 0; i < 4; i++) begin
            tick(1);
            rail_cmp = 4'h1 << i;
            tick(2);
            rdc(8'h01, {2'h0, rail_cmp, 2'h0}, "rail_flag");
        end
        afectl_host_inst.wr(8'h06, 8'h00);
        tick(2);
        rdc(8'h01, 8'h00, "rail_gated");
        // reference low seen briefly stays until the next start
        tick(1);
        rail_cmp = 4'h0;
        conv_active = 1'b1;
        conv_start = 1'b1;
        tick(1);
        conv_start = 1'b0;
        ref_low_cmp = 2'h2;
        tick(1);
        ref_low_cmp = 2'h0;
        tick(2);
        rdc(8'h01, 8'h02, "ref_sticky");
        tick(1);
        conv_start = 1'b1;
        tick(1);
        conv_start = 1'b0;
        tick(2);
        rdc(8'h01, 8'h00, "ref_clear");
        // a low seen on the start cycle survives the clear
        tick(1);
        conv_start = 1'b1;
        ref_low_cmp = 2'h1;
        tick(1);
        conv_start = 1'b0;
        ref_low_cmp = 2'h0;
        tick(2);
        rdc(8'h01, 8'h01, "ref_start_set");
        // reset in mid-run restores the defaults
        tick(1);
        rstn = 1'b0;
        tick(3);
        rstn = 1'b1;
        rdc(8'h02, 8'h01, "inmux_rst2");
        rdc(8'h01, 8'h00, "status_rst2");
        check("ref_rst2", ref_route, 2'h0);
        conclude();
    end
endmodule
